// *** hdl/lts_pkg.sv ***
package lts_pkg;
   localparam int NPORT = 5;
   localparam int NCNT  = 32;
   localparam int NSTAT = NPORT * NCNT;
   localparam int NENT  = 1024;
   localparam int LEN_W = 11;
   localparam int CNT_W = 30;

   // Register indices; byte address is four times the index
   localparam logic [6:0] IDX_CFG   = 7'h6d;
   localparam logic [6:0] IDX_CTRL  = 7'h6e;
   localparam logic [6:0] IDX_ADDR  = 7'h6f;
   localparam logic [6:0] IDX_DATA0 = 7'h70;
   localparam logic [6:0] IDX_DATA8 = 7'h78;

   localparam logic [7:0]  CTRL_RST = 8'h00;
   localparam logic [7:0]  CFG_RST  = 8'h00;
   localparam logic [71:0] DATA_RST = 72'h80_0000_0000_0000_0000;
   localparam logic [2:0]  SEL_TABLE = 3'h6;
   localparam logic [2:0]  SEL_MIB   = 3'h7;
   localparam logic [9:0]  MIB_LAST  = 10'h09f;
   localparam int CFG_LEGACY_BIT = 0;
   localparam int CFG_HUGE_BIT   = 1;

   // Entry and counter word bit positions
   localparam int B_EMPTY  = 71;
   localparam int B_CNT_LO = 61;
   localparam int B_BUSY   = 55;
   localparam int B_OVF    = 31;
   localparam int B_VALID  = 30;

   // Frame length thresholds
   localparam logic [10:0] LEN_MIN    = 11'h040;
   localparam logic [10:0] LEN_BIN2   = 11'h07f;
   localparam logic [10:0] LEN_BIN3   = 11'h0ff;
   localparam logic [10:0] LEN_BIN4   = 11'h1ff;
   localparam logic [10:0] LEN_BIN5   = 11'h3ff;
   localparam logic [10:0] LIM_STD    = 11'h5f2;
   localparam logic [10:0] LIM_LEGACY = 11'h600;
   localparam logic [10:0] LEN_JAB    = 11'h77c;
   localparam logic [10:0] ONE        = 11'h001;

   // Counter offsets within a port bank
   localparam int RX_LOW_PRIO_OCTETS  = 0;
   localparam int RX_HIGH_PRIO_OCTETS = 1;
   localparam int RX_SHORT_GOOD       = 2;
   localparam int RX_SHORT_BAD        = 3;
   localparam int RX_LONG_GOOD        = 4;
   localparam int RX_LONG_BAD         = 5;
   localparam int RX_BAD_SYMBOL       = 6;
   localparam int RX_CHECK_FAIL       = 7;
   localparam int RX_FRACT_BYTE       = 8;
   localparam int RX_CONTROL          = 9;
   localparam int RX_PAUSE            = 10;
   localparam int RX_BCAST            = 11;
   localparam int RX_MCAST            = 12;
   localparam int RX_UCAST            = 13;
   localparam int RX_LEN_MIN_BIN      = 14;
   localparam int TX_LOW_PRIO_OCTETS  = 20;
   localparam int TX_HIGH_PRIO_OCTETS = 21;
   localparam int TX_LATE_COLL        = 22;
   localparam int TX_PAUSE            = 23;
   localparam int TX_BCAST            = 24;
   localparam int TX_MCAST            = 25;
   localparam int TX_UCAST            = 26;
   localparam int TX_DEFERRED         = 27;
   localparam int TX_ALL_COLL         = 28;
   localparam int TX_ABANDONED        = 29;
   localparam int TX_ONE_COLL         = 30;
   localparam int TX_MULTI_COLL       = 31;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_TBL  = 2'b01,
      ST_MIB  = 2'b10
   } lts_fetch_t;

   typedef struct packed {
      logic        done;
      logic [10:0] len;
      logic        prio;
      logic        fcsOk;
      logic        symErr;
      logic        dribble;
      logic        bcast;
      logic        mcast;
      logic        ctrlType;
      logic        pauseOk;
   } lts_rx_frame_t;

   typedef struct packed {
      logic        done;
      logic [10:0] len;
      logic        prio;
      logic        err;
      logic        pause;
      logic        bcast;
      logic        mcast;
      logic        deferred;
      logic [3:0]  collCnt;
      logic        excess;
      logic        lateColl;
      logic        coll;
   } lts_tx_frame_t;

   typedef struct packed {
      logic [1:0]  stamp;
      logic [2:0]  port;
      logic [6:0]  filter_id;
      logic [47:0] mac;
   } lts_entry_t;

   typedef struct packed {
      logic        ovf;
      logic [29:0] cnt;
   } lts_stat_t;

   typedef logic [NCNT-1:0][LEN_W-1:0] lts_amt_t;

   typedef struct packed {
      logic [10:0]     cnt;
      logic [NENT-1:0] vld;
      lts_entry_t      rd;
   } lts_store_t;

   typedef struct packed {
      logic [7:0]             ctrl;
      logic [7:0]             cfg;
      logic [71:0]            data;
      lts_fetch_t             state;
      logic [9:0]             idx;
      logic [31:0]            prdata;
      logic                   pready;
      logic                   pslverr;
      lts_stat_t [NSTAT-1:0]  stat;
   } lts_main_t;
endpackage : lts_pkg

// *** hdl/lts_frame_classify.sv ***
module lts_frame_classify (
   // Frame reports
   input  wire lts_pkg::lts_rx_frame_t rx,
   input  wire lts_pkg::lts_tx_frame_t tx,
   // Size setting
   input  wire logic                   cfgLegacy,
   input  wire logic                   cfgHuge,
   // Per-counter increment
   output lts_pkg::lts_amt_t           amt
);
   logic [10:0] lim;
   logic        good;
   logic        inRange;

   always_comb begin
      lim     = cfgLegacy ? lts_pkg::LIM_LEGACY : lts_pkg::LIM_STD;   // [RULE_13]
      good    = rx.fcsOk && !rx.symErr && !rx.dribble;
      inRange = (rx.len >= lts_pkg::LEN_MIN) && (rx.len <= lim);
      amt     = '0;
      if (rx.done) begin
         if (rx.prio) amt[lts_pkg::RX_HIGH_PRIO_OCTETS] = rx.len;   // [RULE_11]
         else amt[lts_pkg::RX_LOW_PRIO_OCTETS] = rx.len;            // [RULE_11]
         if (rx.len < lts_pkg::LEN_MIN) begin
            if (good) amt[lts_pkg::RX_SHORT_GOOD] = lts_pkg::ONE;   // [RULE_12]
            else amt[lts_pkg::RX_SHORT_BAD] = lts_pkg::ONE;         // [RULE_12]
         end
         if (rx.len > lim && good) amt[lts_pkg::RX_LONG_GOOD] = lts_pkg::ONE;   // [RULE_13]
         if (cfgHuge ? (rx.len > lts_pkg::LEN_JAB) : (rx.len > lts_pkg::LIM_STD && !good)) begin
            amt[lts_pkg::RX_LONG_BAD] = lts_pkg::ONE;               // [RULE_14]
         end
         if (inRange && rx.symErr) amt[lts_pkg::RX_BAD_SYMBOL] = lts_pkg::ONE;   // [RULE_12]
         if (inRange && !rx.symErr && !rx.fcsOk) begin
            if (rx.dribble) amt[lts_pkg::RX_FRACT_BYTE] = lts_pkg::ONE;   // [RULE_15]
            else amt[lts_pkg::RX_CHECK_FAIL] = lts_pkg::ONE;              // [RULE_15]
         end
         if (rx.ctrlType) amt[lts_pkg::RX_CONTROL] = lts_pkg::ONE;        // [RULE_16]
         if (rx.ctrlType && rx.pauseOk && rx.fcsOk && rx.len >= lts_pkg::LEN_MIN) begin
            amt[lts_pkg::RX_PAUSE] = lts_pkg::ONE;                        // [RULE_16]
         end
         if (good) begin
            if (rx.bcast) amt[lts_pkg::RX_BCAST] = lts_pkg::ONE;          // [RULE_17]
            else if (rx.mcast && !rx.ctrlType) amt[lts_pkg::RX_MCAST] = lts_pkg::ONE;
            else if (!rx.mcast) amt[lts_pkg::RX_UCAST] = lts_pkg::ONE;    // [RULE_17]
         end
         if (rx.len == lts_pkg::LEN_MIN) amt[lts_pkg::RX_LEN_MIN_BIN] = lts_pkg::ONE;   // [RULE_18]
         else if (rx.len > lts_pkg::LEN_MIN && rx.len <= lts_pkg::LEN_BIN2) amt[15] = lts_pkg::ONE;
         else if (rx.len > lts_pkg::LEN_BIN2 && rx.len <= lts_pkg::LEN_BIN3) amt[16] = lts_pkg::ONE;
         else if (rx.len > lts_pkg::LEN_BIN3 && rx.len <= lts_pkg::LEN_BIN4) amt[17] = lts_pkg::ONE;
         else if (rx.len > lts_pkg::LEN_BIN4 && rx.len <= lts_pkg::LEN_BIN5) amt[18] = lts_pkg::ONE;
         else if (rx.len > lts_pkg::LEN_BIN5 && rx.len <= lim) amt[19] = lts_pkg::ONE;   // [RULE_18]
      end
      if (tx.done && !tx.err) begin
         if (tx.prio) amt[lts_pkg::TX_HIGH_PRIO_OCTETS] = tx.len;   // [RULE_19]
         else amt[lts_pkg::TX_LOW_PRIO_OCTETS] = tx.len;            // [RULE_19]
         if (tx.bcast) amt[lts_pkg::TX_BCAST] = lts_pkg::ONE;       // [RULE_21]
         else if (tx.mcast) amt[lts_pkg::TX_MCAST] = lts_pkg::ONE;
         else amt[lts_pkg::TX_UCAST] = lts_pkg::ONE;                // [RULE_21]
         if (tx.collCnt == 4'h1) amt[lts_pkg::TX_ONE_COLL] = lts_pkg::ONE;   // [RULE_22]
         if (tx.collCnt > 4'h1) amt[lts_pkg::TX_MULTI_COLL] = lts_pkg::ONE;  // [RULE_22]
      end
      if (tx.done && tx.pause) amt[lts_pkg::TX_PAUSE] = lts_pkg::ONE;        // [RULE_21]
      if (tx.done && tx.deferred) amt[lts_pkg::TX_DEFERRED] = lts_pkg::ONE;  // [RULE_22]
      if (tx.lateColl) amt[lts_pkg::TX_LATE_COLL] = lts_pkg::ONE;            // [RULE_20]
      if (tx.coll) amt[lts_pkg::TX_ALL_COLL] = lts_pkg::ONE;                 // [RULE_22]
      if (tx.excess) amt[lts_pkg::TX_ABANDONED] = lts_pkg::ONE;              // [RULE_22]
   end
endmodule : lts_frame_classify

// *** hdl/lts_table_store.sv ***
module lts_table_store (
   // Clock and reset
   input  wire logic                clk,
   input  wire logic                arst_n,
   // Learning engine write
   input  wire logic                lrnWe,
   input  wire logic [9:0]          lrnIdx,
   input  wire logic                lrnValid,
   input  wire lts_pkg::lts_entry_t lrnEntry,
   // Readout
   input  wire logic                rdEn,
   input  wire logic [9:0]          rdIdx,
   output lts_pkg::lts_entry_t      rdEntry,
   output logic                     tblEmpty,
   output logic [9:0]               cntField
);
   lts_pkg::lts_entry_t mem [lts_pkg::NENT];
   lts_pkg::lts_store_t q;
   lts_pkg::lts_store_t d;
   logic                wasValid;

   // Only the learning engine writes; there is no host write path
   always_comb begin
      d        = q;
      wasValid = q.vld[lrnIdx];
      if (rdEn) d.rd = q.vld[rdIdx] ? mem[rdIdx] : '0;
      if (lrnWe) begin
         d.vld[lrnIdx] = lrnValid;                                      // [RULE_01]
         if (lrnValid && !wasValid) d.cnt = q.cnt + 11'h001;
         else if (!lrnValid && wasValid) d.cnt = q.cnt - 11'h001;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   // Stamp and source port are kept as the learning engine ages them
   always_ff @(posedge clk) begin
      if (lrnWe) begin
         mem[lrnIdx] <= lrnEntry;                                       // [RULE_04] [RULE_05]
      end
   end

   assign rdEntry  = q.rd;
   assign tblEmpty = (q.cnt == 11'h000);                                // [RULE_02]
   assign cntField = tblEmpty ? 10'h000 : 10'(q.cnt - 11'h001);        // [RULE_03]

   AST_LEARN_FILLS: assert property (@(posedge clk) disable iff (!arst_n)   // [RULE_02]
      (tblEmpty && lrnWe && lrnValid) |=> (!tblEmpty && cntField == 10'h000))
      else $error("first learned entry did not clear the empty flag");
endmodule : lts_table_store

// *** hdl/lts_readout.sv ***
// Functional notes
// RULE_01: Only hardware maintains learned table; host reads.
// RULE_02: Bit 71 empty flag, resets to one.
// RULE_03: Bits 70-61 hold valid count minus one.
// RULE_04: Bits 60-59 hold two-bit aging stamp.
// RULE_05: Bits 58-56 encode learning port.
// RULE_06: Bit 55 high while entry fetch pending.
// RULE_07: Host rereads from bit-55 byte when busy.
// RULE_08: Entry spread over data registers 112-120.
// RULE_09: Host writes select code, then index triggers.
// RULE_10: Five port banks of 32 counters.
// RULE_11: Offsets 0,1 count received octets.
// RULE_12: Short good, short bad, bad-symbol frames.
// RULE_13: Offset 4 counts long good frames.
// RULE_14: Offset 5 counts long bad frames.
// RULE_15: Offsets 7,8 count check failures.
// RULE_16: Offsets 9,10 count control, pause frames.
// RULE_17: Offsets 11-13 count good cast types.
// RULE_18: Offsets 14-19 count frames by length.
// RULE_19: Offsets 20,21 count transmitted octets.
// RULE_20: Offset 22 counts late collisions.
// RULE_21: Offsets 23-26 count pause, cast types.
// RULE_22: Offsets 27-31 count defer and collisions.
// RULE_23: Counter word: overflow, valid, 30-bit count.
// RULE_24: Reading a counter clears it.
// RULE_25: Host selects counter, triggers, reads 117-120.
// RULE_26: Data registers hold until next trigger.
//
// Decided for this implementation: the placing of the registers and the APB slave port.
module lts_readout (
   // Clock and reset
   input  wire logic                                      clk,
   input  wire logic                                      arst_n,
   // APB slave
   input  wire logic                                      psel,
   input  wire logic                                      penable,
   input  wire logic                                      pwrite,
   input  wire logic [8:0]                                paddr,
   input  wire logic [31:0]                               pwdata,
   output logic [31:0]                                    prdata,
   output logic                                           pready,
   output logic                                           pslverr,
   // Learning engine
   input  wire logic                                      lrnWe,
   input  wire logic [9:0]                                lrnIdx,
   input  wire logic                                      lrnValid,
   input  wire lts_pkg::lts_entry_t                       lrnEntry,
   // Per-port frame reports
   input  wire lts_pkg::lts_rx_frame_t [lts_pkg::NPORT-1:0] rxFrame,
   input  wire lts_pkg::lts_tx_frame_t [lts_pkg::NPORT-1:0] txFrame
);
   lts_pkg::lts_main_t                   q;
   lts_pkg::lts_main_t                   d;
   lts_pkg::lts_amt_t [lts_pkg::NPORT-1:0] amtVec;
   lts_pkg::lts_entry_t                  rdEntry;
   logic                                 tblEmpty;
   logic [9:0]                           cntField;
   logic                                 tblRd;
   logic [6:0]                           regIdx;
   logic                                 access;
   logic                                 commit;
   logic                                 wrAddr;
   logic                                 isData;
   logic                                 mapped;
   logic [3:0]                           byteSel;
   logic [7:0]                           rdByte;
   logic                                 clr;
   lts_pkg::lts_stat_t                   base;
   logic [30:0]                          sum;

   genvar gp;
   generate
      for (gp = 0; gp < lts_pkg::NPORT; gp++) begin : g_port
         // Each port bank sits at base 32 * port with identical layout
         lts_frame_classify u_classify (                                // [RULE_10]
            .rx        (rxFrame[gp]),
            .tx        (txFrame[gp]),
            .cfgLegacy (q.cfg[lts_pkg::CFG_LEGACY_BIT]),
            .cfgHuge   (q.cfg[lts_pkg::CFG_HUGE_BIT]),
            .amt       (amtVec[gp])
         );
      end
   endgenerate

   lts_table_store u_store (
      .clk      (clk),
      .arst_n   (arst_n),
      .lrnWe    (lrnWe),
      .lrnIdx   (lrnIdx),
      .lrnValid (lrnValid),
      .lrnEntry (lrnEntry),
      .rdEn     (tblRd),
      .rdIdx    (d.idx),
      .rdEntry  (rdEntry),
      .tblEmpty (tblEmpty),
      .cntField (cntField)
   );

   always_comb begin
      d       = q;
      tblRd   = 1'b0;
      clr     = 1'b0;
      base    = '0;
      sum     = '0;
      regIdx  = paddr[8:2];
      access  = psel && penable;
      commit  = access && q.pready && !q.pslverr;
      isData  = (regIdx >= lts_pkg::IDX_DATA0) && (regIdx <= lts_pkg::IDX_DATA8);
      mapped  = (paddr[1:0] == 2'b00) && (isData || regIdx == lts_pkg::IDX_CFG
                || regIdx == lts_pkg::IDX_CTRL || regIdx == lts_pkg::IDX_ADDR);
      wrAddr  = commit && pwrite && regIdx == lts_pkg::IDX_ADDR;
      byteSel = 4'(regIdx - lts_pkg::IDX_DATA0);
      // Register 112 carries bits 71-64, register 120 bits 7-0
      rdByte  = 8'(q.data >> {4'h8 - byteSel, 3'b000});               // [RULE_08]

      // One wait state: answer is prepared in the first access cycle
      d.pready = 1'b0;
      if (access && !q.pready) begin
         d.pready  = 1'b1;
         d.pslverr = !mapped || (pwrite && isData);                     // [RULE_01]
         d.prdata  = 32'h0000_0000;
         if (!pwrite) begin
            if (isData) d.prdata = {24'h00_0000, rdByte};
            else if (regIdx == lts_pkg::IDX_CFG) d.prdata = {24'h00_0000, q.cfg};
            else if (regIdx == lts_pkg::IDX_CTRL) d.prdata = {24'h00_0000, q.ctrl};
            else if (regIdx == lts_pkg::IDX_ADDR) d.prdata = {24'h00_0000, q.idx[7:0]};
         end
      end else if (!access) begin
         d.pslverr = 1'b0;
      end

      if (commit && pwrite && regIdx == lts_pkg::IDX_CFG) d.cfg = pwdata[7:0];
      if (commit && pwrite && regIdx == lts_pkg::IDX_CTRL) d.ctrl = pwdata[7:0];

      // Fetch sequencer; data only changes on a trigger and its completion
      case (q.state)
         lts_pkg::ST_IDLE: begin
            if (wrAddr) begin
               d.idx = {q.ctrl[1:0], pwdata[7:0]};
               if (q.ctrl[4:2] == lts_pkg::SEL_TABLE) begin
                  tblRd                   = 1'b1;
                  d.state                 = lts_pkg::ST_TBL;
                  d.data[lts_pkg::B_BUSY] = 1'b1;                       // [RULE_06]
               end else if (q.ctrl[4:2] == lts_pkg::SEL_MIB) begin
                  d.state                  = lts_pkg::ST_MIB;
                  d.data[lts_pkg::B_VALID] = 1'b0;                      // [RULE_23]
               end
            end
         end
         lts_pkg::ST_TBL: begin
            d.data  = {tblEmpty, cntField, rdEntry.stamp, rdEntry.port, 1'b0,
                       rdEntry.filter_id, rdEntry.mac};                       // [RULE_02] [RULE_03] [RULE_08]
            d.state = lts_pkg::ST_IDLE;
         end
         lts_pkg::ST_MIB: begin
            d.data = {40'h00_0000_0000, 1'b0, 1'b1, 30'h0000_0000};
            if (q.idx <= lts_pkg::MIB_LAST) begin
               d.data[lts_pkg::B_OVF] = q.stat[q.idx[7:0]].ovf;        // [RULE_23]
               d.data[29:0]           = q.stat[q.idx[7:0]].cnt;
            end
            d.state = lts_pkg::ST_IDLE;
         end
         default: begin
            d.state = lts_pkg::ST_IDLE;
         end
      endcase

      // Counter update; a read clears, but events of that cycle still count
      for (int i = 0; i < lts_pkg::NSTAT; i++) begin
         clr  = (q.state == lts_pkg::ST_MIB) && (q.idx == 10'(i));    // [RULE_24]
         base = clr ? '0 : q.stat[i];
         sum  = {1'b0, base.cnt} + 31'(amtVec[i / lts_pkg::NCNT][i % lts_pkg::NCNT]);
         d.stat[i].cnt = sum[29:0];
         d.stat[i].ovf = base.ovf | sum[30];                            // [RULE_23]
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         q       <= '0;
         q.ctrl  <= lts_pkg::CTRL_RST;
         q.cfg   <= lts_pkg::CFG_RST;
         q.data  <= lts_pkg::DATA_RST;                                  // [RULE_02]
         q.state <= lts_pkg::ST_IDLE;
      end else begin
         q <= d;                                                        // [RULE_26]
      end
   end

   assign prdata  = q.prdata;
   assign pready  = q.pready;
   assign pslverr = q.pslverr;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!arst_n);

   sequence s_trig_tbl;
      wrAddr && q.state == lts_pkg::ST_IDLE && q.ctrl[4:2] == lts_pkg::SEL_TABLE;
   endsequence

   sequence s_trig_mib;
      wrAddr && q.state == lts_pkg::ST_IDLE && q.ctrl[4:2] == lts_pkg::SEL_MIB;
   endsequence

   sequence s_tbl_ready;
      !q.data[55] && q.state == lts_pkg::ST_IDLE;
   endsequence

   AST_TBL_BUSY: assert property (s_trig_tbl |=> q.data[55] ##1 s_tbl_ready)   // [RULE_06]
      else $error("entry fetch did not show busy then ready");

   AST_TBL_EMPTY: assert property (                                      // [RULE_03]
      (q.state == lts_pkg::ST_TBL && tblEmpty) |=> (q.data[71] && q.data[70:61] == 10'h000))
      else $error("empty table not reported with zero count");

   AST_MIB_VALID: assert property (s_trig_mib |=> !q.data[30] ##1 q.data[30])   // [RULE_23]
      else $error("counter valid bit did not follow fetch");

   AST_MIB_CLEAR: assert property (                                      // [RULE_24]
      (q.state == lts_pkg::ST_MIB && q.idx == 10'h00e && !rxFrame[0].done)
      |=> q.stat[14].cnt == 30'h0000_0000)
      else $error("counter not cleared by its read");

   AST_DATA_HOLD: assert property (                                      // [RULE_26]
      (q.state == lts_pkg::ST_IDLE && !wrAddr) |=> $stable(q.data))
      else $error("data registers changed without trigger");

   AST_NO_HOST_WRITE: assert property (                                  // [RULE_01]
      (access && !q.pready && pwrite && isData) |=> (q.pready && q.pslverr))
      else $error("write to data register not refused");

   AST_SHORT_GOOD: assert property (                                     // [RULE_12]
      (rxFrame[0].done && rxFrame[0].len < lts_pkg::LEN_MIN && rxFrame[0].fcsOk
       && !rxFrame[0].symErr && !rxFrame[0].dribble && q.state != lts_pkg::ST_MIB)
      |=> q.stat[2].cnt == 30'($past(q.stat[2].cnt) + 30'h1))
      else $error("short good frame not counted");

   AST_RX_OCTETS: assert property (                                      // [RULE_11]
      (rxFrame[0].done && !rxFrame[0].prio && q.state != lts_pkg::ST_MIB)
      |=> q.stat[0].cnt == 30'($past(q.stat[0].cnt) + 30'($past(rxFrame[0].len))))
      else $error("received octets not added");

   AST_APB_WAIT: assert property (                                       // [RULE_08]
      (access && !q.pready) |=> q.pready ##1 !q.pready)
      else $error("APB answer not after one wait state");
endmodule : lts_readout

// *** tb/lts_host_model.sv ***
module lts_host_model (
   // Clock
   input  wire logic        clk,
   // APB master side
   output logic             psel,
   output logic             penable,
   output logic             pwrite,
   output logic [8:0]       paddr,
   output logic [31:0]      pwdata,
   input  wire logic [31:0] prdata,
   input  wire logic        pready,
   input  wire logic        pslverr
);
   timeunit 1ns;
   timeprecision 1ns;
   logic hung = 1'b0;
   initial begin
      {psel, penable, pwrite, paddr, pwdata} = '0;
   end
   task automatic xfer(input logic wr, input logic [6:0] idx, input logic [7:0] wd,
                       output logic [7:0] rd, output logic err);
      int n;
      @(posedge clk);
      psel   <= 1'b1;
      pwrite <= wr;
      paddr  <= {idx, 2'b00};
      pwdata <= {24'h0, wd};
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 64);
      if (n >= 64) hung = 1'b1;
      rd = prdata[7:0];
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : xfer
   // Select, trigger, then read bytes; counters read only the low four
   task automatic fetch(input logic [7:0] code, input logic [7:0] addr, output logic [71:0] d);
      logic e;
      int   i;
      int   tries;
      d = '0;
      xfer(1'b1, lts_pkg::IDX_CTRL, code, d[7:0], e);
      xfer(1'b1, lts_pkg::IDX_ADDR, addr, d[7:0], e);
      i = code[2] ? 5 : 0;
      tries = 0;
      while (i < 9) begin
         xfer(1'b0, lts_pkg::IDX_DATA0 + 7'(i), 8'h00, d[71-8*i -: 8], e);
         tries++;
         if (tries < 32 && i == 2 && d[lts_pkg::B_BUSY]) i = 2;
         else if (tries < 32 && i == 5 && code[2] && !d[lts_pkg::B_VALID]) i = 5;
         else i++;
      end
   endtask : fetch
endmodule : lts_host_model

// *** tb/tb_top.sv ***
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct packed {
      logic [7:0]  code;
      logic [7:0]  addr;
      logic [71:0] exp;
   } lts_row_t;
   localparam logic [59:0] ENT_A = {2'b10, 3'b100, 7'h55, 48'h0123_4567_89ab};
   localparam logic [59:0] ENT_B = {2'b01, 3'b000, 7'h01, 48'hfedc_ba98_7654};
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   logic psel, penable, pwrite, pready, pslverr, lrnWe, lrnValid, e;
   logic [8:0]  paddr;
   logic [31:0] pwdata, prdata;
   logic [9:0]  lrnIdx;
   logic [7:0]  b;
   logic [71:0] d;
   lts_pkg::lts_entry_t                     lrnEntry;
   lts_pkg::lts_rx_frame_t [lts_pkg::NPORT-1:0] rxFrame;
   lts_pkg::lts_tx_frame_t [lts_pkg::NPORT-1:0] txFrame;
   int failures = 0;
   int checks_done = 0;
   lts_row_t rows [13];
   always #50 clk = ~clk;
   lts_host_model host_u (.clk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
                          .pslverr);
   lts_readout dut_u (.clk, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
                      .pready, .pslverr, .lrnWe, .lrnIdx, .lrnValid, .lrnEntry, .rxFrame,
                      .txFrame);
   function automatic lts_row_t trow(input logic [7:0] c, a, input logic [59:0] x);
      return '{c, a, {1'b0, 10'h001, x[59:55], 1'b0, x[54:0]}};
   endfunction : trow
   function automatic lts_row_t crow(input logic [7:0] a, input logic [29:0] n);
      return '{8'h1c, a, {40'h0, 2'b01, n}};
   endfunction : crow
   task automatic chk(input string what, input logic [71:0] got, input logic [71:0] exp);
      checks_done++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] %s exp %h got %h", what, exp, got);
      end
   endtask : chk
   task automatic tally_and_finish;
      if (failures == 0 && checks_done > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : tally_and_finish
   task automatic learn(input logic [9:0] idx, input logic [59:0] x);
      @(posedge clk);
      {lrnWe, lrnValid, lrnIdx, lrnEntry} <= {2'b11, idx, x};
      @(posedge clk);
      lrnWe <= 1'b0;
   endtask : learn
   always @(posedge host_u.hung) begin
      failures++;
      tally_and_finish();
   end
   initial begin
      repeat (20000) @(posedge clk);
      failures++;
      tally_and_finish();
   end
   initial begin
      {lrnWe, lrnValid, lrnIdx, lrnEntry, rxFrame, txFrame} = '0;
      rows = '{trow(8'h18, 8'h03, ENT_A), trow(8'h19, 8'h01, ENT_B), trow(8'h18, 8'h05, '0),
               crow(8'h2e, 30'd1), crow(8'h2e, 30'd0), crow(8'h20, 30'd64), crow(8'h2d, 30'd1),
               crow(8'h95, 30'd100), crow(8'h98, 30'd1), crow(8'h02, 30'd1), crow(8'h00, 30'd60),
               crow(8'h0e, 30'd0), '{8'h1d, 8'h00, {40'h0, 32'h4000_0000}}};
      repeat (8) @(posedge clk);
      arst_n <= 1'b1;
      host_u.xfer(1'b0, lts_pkg::IDX_DATA0, 8'h00, b, e);
      chk("data0_rst", 72'(b), 72'h80);
      // Table read before anything is learned shows the empty flag and zero count
      host_u.fetch(8'h18, 8'h00, d);
      chk("tbl_empty", d, {1'b1, 71'h0});
      learn(10'h003, ENT_A);
      learn(10'h101, ENT_B);
      @(posedge clk);
      rxFrame[0] <= '{done: 1'b1, len: 11'd60, fcsOk: 1'b1, default: '0};
      rxFrame[1] <= '{done: 1'b1, len: 11'd64, fcsOk: 1'b1, default: '0};
      txFrame[4] <= '{done: 1'b1, len: 11'd100, prio: 1'b1, bcast: 1'b1, default: '0};
      @(posedge clk);
      rxFrame <= '0;
      txFrame <= '0;
      foreach (rows[i]) begin
         host_u.fetch(rows[i].code, rows[i].addr, d);
         chk("fetch", d, rows[i].exp);
      end
      // Data registers refuse host writes and keep the last result
      host_u.xfer(1'b1, lts_pkg::IDX_DATA8, 8'hff, b, e);
      chk("ro_err", 72'(e), 72'h1);
      host_u.xfer(1'b0, lts_pkg::IDX_DATA8, 8'h00, b, e);
      chk("data8_hold", 72'(b), 72'h0);
      // The 1536 limit keeps a 1530-byte good frame out of the long count
      host_u.xfer(1'b1, lts_pkg::IDX_CFG, 8'h01, b, e);
      host_u.xfer(1'b0, lts_pkg::IDX_CFG, 8'h00, b, e);
      chk("cfg", 72'(b), 72'h1);
      @(posedge clk);
      rxFrame[0] <= '{done: 1'b1, len: 11'd1530, fcsOk: 1'b1, default: '0};
      @(posedge clk);
      rxFrame <= '0;
      host_u.fetch(8'h1c, 8'h04, d);
      chk("long_good", d, 72'h4000_0000);
      host_u.fetch(8'h1c, 8'h13, d);
      chk("len_bin_6", d, 72'h4000_0001);
      tally_and_finish();
   end
endmodule : tb_top
